// >>> logic/adc_avg_cmp_map.vh
// Register offsets, field positions and reset values of the average and compare logic.
`ifndef ADC_AVG_CMP_MAP_VH
`define ADC_AVG_CMP_MAP_VH

// ****************************************
// Register offsets.
// ****************************************
`define OFS_CONTROL       4'h0
`define OFS_COMPARE_ONE   4'h1
`define OFS_COMPARE_TWO   4'h2
`define OFS_STATUS        4'h3
`define OFS_MASK          4'h4
`define OFS_RESULT        4'h5
`define OFS_LAST_SAMPLE   4'h6

// ****************************************
// Control register fields.
// ****************************************
`define CTL_AVG_EN_BIT    0
`define CTL_AVG_SEL_LO    1
`define CTL_AVG_SEL_HI    2
`define CTL_CMP_EN_BIT    3
`define CTL_CMP_GT_BIT    4
`define CTL_CMP_RANGE_BIT 5
`define CTL_ABORT_BIT     6

// ****************************************
// Status and mask fields.
// ****************************************
`define STS_COMPLETE_BIT  0
`define STS_ACTIVE_BIT    1

// ****************************************
// Reset values.
// ****************************************
`define RST_CONTROL       16'h0000
`define RST_COMPARE       16'h0000
`define RST_RESULT        16'h0000
`define RST_MASK          16'h0000

`endif

// >>> logic/adc_avg_cmp.v
// Result averaging, automatic compare and completion flag logic of the converter.
`timescale 1ns/1ps
`default_nettype none
`include "adc_avg_cmp_map.vh"

// How it works
// - Average 4, 8, 16 or 32 when enabled.
// - Active flag high throughout an averaging sequence.
// - Accumulate results; average after the last one.
// - No complete flag for intermediate averaging conversions.
// - Compare off or true: store, set complete.
// - Interrupt when complete set and enabled.
// - Averaging runs in wait and stop3.
// - Threshold mode: true when result below one.
// - Greater mode: true when result at least one.
// - Range, one<=two, clear: below one or above two.
// - Range, one>two, clear: below one and above two.
// - Range, one<=two, set: inclusive inside range.
// - Range, one>two, set: inclusive outside range.
// - Compare false: no flag, no result update.
// - Compare acts on averaged value when averaging.
// - Compare monitoring continues in wait and stop3.
// - Abort leaves last good result unchanged.
module adc_avg_cmp #(
  parameter WIDTH = 16
) (
  input  wire             CLK_I,
  input  wire             RESET_N_I,
  input  wire [3:0]       ADDR_I,
  input  wire [15:0]      WDATA_I,
  input  wire             WRITE_I,
  input  wire             READ_I,
  output reg  [15:0]      RDATA_O,
  input  wire [WIDTH-1:0] SAMPLE_I,
  input  wire             SAMPLE_VALID_I,
  input  wire             LOW_POWER_I,
  output reg              CONVERSION_ACTIVE_O,
  output reg              RESULT_UPDATE_O,
  output reg  [WIDTH-1:0] RESULT_O,
  output reg              IRQ_O
);

  // ****************************************
  // Compare function.
  // ****************************************

  // Evaluates the selected compare mode; shared by single and averaged results.
  function cmp_true;
    input [WIDTH-1:0] value;
    input [WIDTH-1:0] one;
    input [WIDTH-1:0] two;
    input             gt;
    input             range;
    reg               below_one;
    reg               at_least_one;
    reg               above_two;
    reg               at_most_two;
    begin
      below_one    = value < one;
      at_least_one = !below_one;
      above_two    = value > two;
      at_most_two  = !above_two;
      if (!range) begin
        cmp_true = gt ? at_least_one : below_one;
      end else if (one <= two) begin
        cmp_true = gt ? (at_least_one && at_most_two) : (below_one || above_two);
      end else begin
        cmp_true = gt ? (at_least_one || at_most_two) : (below_one && above_two);
      end
    end
  endfunction

  // Maps the count select code to the log2 of the number of conversions.
  function [2:0] count_log2;
    input [1:0] sel;
    begin
      count_log2 = {1'b0, sel} + 3'd2;
    end
  endfunction

  // ****************************************
  // Registers.
  // ****************************************
  localparam ACC_W = WIDTH + 5;
  localparam ST_IDLE = 1'b0;
  localparam ST_AVG  = 1'b1;

  reg  [15:0]      control;
  reg  [WIDTH-1:0] compare_value_one;
  reg  [WIDTH-1:0] compare_value_two;
  reg              conversion_complete_flag;
  reg  [1:0]       mask;
  reg  [WIDTH-1:0] last_sample;
  reg  [ACC_W-1:0] accumulator;
  reg  [5:0]       sample_count;
  reg              state;
  reg              low_power_meta;
  reg              low_power_sync;

  wire             average_enable       = control[`CTL_AVG_EN_BIT];
  wire [1:0]       average_count_select = control[`CTL_AVG_SEL_HI:`CTL_AVG_SEL_LO];
  wire             compare_enable       = control[`CTL_CMP_EN_BIT];
  wire             compare_greater_select = control[`CTL_CMP_GT_BIT];
  wire             compare_range_enable = control[`CTL_CMP_RANGE_BIT];
  wire             write_ctl  = WRITE_I && (ADDR_I == `OFS_CONTROL);
  wire             write_cfg  = WRITE_I && ((ADDR_I == `OFS_CONTROL) ||
                                (ADDR_I == `OFS_COMPARE_ONE) || (ADDR_I == `OFS_COMPARE_TWO));
  // Any configuration write invalidates a running sequence, as does an explicit abort.
  wire             abort      = write_cfg ||
                                (write_ctl && WDATA_I[`CTL_ABORT_BIT]);

  // ****************************************
  // Averaging datapath.
  // ****************************************
  reg  [ACC_W-1:0] next_sum;
  reg  [WIDTH-1:0] final_value;
  reg              final_ready;
  reg  [5:0]       target;

  // Forms the running sum and the final value of this cycle, if any.
  always @* begin
    target      = 6'd1 << count_log2(average_count_select);
    next_sum    = ((state == ST_IDLE) ? {ACC_W{1'b0}} : accumulator) +
                  {{(ACC_W-WIDTH){1'b0}}, SAMPLE_I};
    final_ready = 1'b0;
    final_value = SAMPLE_I;
    if (SAMPLE_VALID_I && !abort) begin
      if (!average_enable) begin
        final_ready = 1'b1;
      end else if (sample_count + 6'd1 == target) begin
        final_ready = 1'b1;
        final_value = next_sum[WIDTH-1+count_log2(average_count_select) -: WIDTH];
      end
    end
  end

  // Compare acts on whatever final value is formed, averaged or single.
  wire commit = final_ready && (!compare_enable ||
                cmp_true(final_value, compare_value_one, compare_value_two,
                         compare_greater_select, compare_range_enable));

  // ****************************************
  // Low-power indication synchroniser.
  // ****************************************

  // The low-power level is informational only; sequences never stop for it.
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      low_power_meta <= 1'b0;
      low_power_sync <= 1'b0;
    end else begin
      low_power_meta <= LOW_POWER_I;
      low_power_sync <= low_power_meta;
    end
  end

  // ****************************************
  // Sequence control.
  // ****************************************

  // Counts conversions of an averaging sequence; wait and stop3 do not halt it.
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state        <= ST_IDLE;
      accumulator  <= {ACC_W{1'b0}};
      sample_count <= 6'd0;
      last_sample  <= {WIDTH{1'b0}};
    end else begin
      if (SAMPLE_VALID_I) begin
        last_sample <= SAMPLE_I;
      end
      case (state)
        ST_IDLE: begin
          if (SAMPLE_VALID_I && average_enable && !abort && !final_ready) begin
            state        <= ST_AVG;
            accumulator  <= next_sum;
            sample_count <= 6'd1;
          end
        end
        ST_AVG: begin
          if (abort || final_ready) begin
            state        <= ST_IDLE;
            sample_count <= 6'd0;
          end else if (SAMPLE_VALID_I) begin
            accumulator  <= next_sum;
            sample_count <= sample_count + 6'd1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Result, flags and interrupt.
  // ****************************************

  // A new completion wins over a write-one clear in the same cycle.
  // The active status bit is a level, not an event, so it never raises the interrupt.
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RESULT_O                 <= `RST_RESULT;
      RESULT_UPDATE_O          <= 1'b0;
      conversion_complete_flag <= 1'b0;
      CONVERSION_ACTIVE_O      <= 1'b0;
      IRQ_O                    <= 1'b0;
    end else begin
      RESULT_UPDATE_O <= commit;
      if (commit) begin
        RESULT_O                 <= final_value;
        conversion_complete_flag <= 1'b1;
      end else if (WRITE_I && (ADDR_I == `OFS_STATUS) && WDATA_I[`STS_COMPLETE_BIT]) begin
        conversion_complete_flag <= 1'b0;
      end
      CONVERSION_ACTIVE_O <= (state == ST_AVG && !abort && !final_ready) ||
                             (state == ST_IDLE && SAMPLE_VALID_I && average_enable &&
                              !abort && !final_ready);
      IRQ_O <= (commit || (conversion_complete_flag &&
                !(WRITE_I && (ADDR_I == `OFS_STATUS) && WDATA_I[`STS_COMPLETE_BIT]))) &&
               mask[`STS_COMPLETE_BIT];
    end
  end

  // ****************************************
  // Register bus.
  // ****************************************

  // Software writes; configuration changes also abort a running sequence.
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      control           <= `RST_CONTROL;
      compare_value_one <= `RST_COMPARE;
      compare_value_two <= `RST_COMPARE;
      mask              <= 2'b00;
    end else if (WRITE_I) begin
      case (ADDR_I)
        `OFS_CONTROL:     control           <= WDATA_I & 16'h003F;
        `OFS_COMPARE_ONE: compare_value_one <= WDATA_I[WIDTH-1:0];
        `OFS_COMPARE_TWO: compare_value_two <= WDATA_I[WIDTH-1:0];
        `OFS_MASK:        mask              <= WDATA_I[1:0];
        default:          mask              <= mask;
      endcase
    end
  end

  // Read data stand in the cycle after the strobe only; unmapped reads give zero.
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RDATA_O <= 16'h0000;
    end else if (READ_I) begin
      case (ADDR_I)
        `OFS_CONTROL:     RDATA_O <= control;
        `OFS_COMPARE_ONE: RDATA_O <= compare_value_one;
        `OFS_COMPARE_TWO: RDATA_O <= compare_value_two;
        `OFS_STATUS:      RDATA_O <= {13'h0000, low_power_sync, CONVERSION_ACTIVE_O,
                                      conversion_complete_flag};
        `OFS_MASK:        RDATA_O <= {14'h0000, mask};
        `OFS_RESULT:      RDATA_O <= RESULT_O;
        `OFS_LAST_SAMPLE: RDATA_O <= last_sample;
        default:          RDATA_O <= 16'h0000;
      endcase
    end else begin
      RDATA_O <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// >>> test/adc_avg_cmp_monitor.sv
// Port-level checker of the average and compare logic.
`timescale 1ns/1ps
`default_nettype none
module adc_avg_cmp_chk #(
  parameter WIDTH = 16
) (
  input wire logic             CLK_I,
  input wire logic             RESET_N_I,
  input wire logic [3:0]       ADDR_I,
  input wire logic [15:0]      WDATA_I,
  input wire logic             WRITE_I,
  input wire logic             READ_I,
  input wire logic [15:0]      RDATA_O,
  input wire logic             SAMPLE_VALID_I,
  input wire logic             CONVERSION_ACTIVE_O,
  input wire logic             RESULT_UPDATE_O,
  input wire logic [WIDTH-1:0] RESULT_O,
  input wire logic             IRQ_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Shadow of mask bit 0, so the interrupt can be tied to the commit that caused it.
  logic mask_on;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I)
      mask_on <= 1'b0;
    else if (WRITE_I && ADDR_I == 4'h4)
      mask_on <= WDATA_I[0];
  end
  property p_hold; $changed(RESULT_O) |-> RESULT_UPDATE_O; endproperty
  a_hold: assert property (p_hold) else $error("result moved without commit");
  property p_cause; RESULT_UPDATE_O |-> $past(SAMPLE_VALID_I); endproperty
  a_cause: assert property (p_cause) else $error("commit without sample");
  property p_mid; CONVERSION_ACTIVE_O |-> !RESULT_UPDATE_O; endproperty
  a_mid: assert property (p_mid) else $error("commit inside sequence");
  property p_start; $rose(CONVERSION_ACTIVE_O) |-> $past(SAMPLE_VALID_I); endproperty
  a_start: assert property (p_start) else $error("active rose without sample");
  property p_keep; CONVERSION_ACTIVE_O && !SAMPLE_VALID_I && !WRITE_I |=> CONVERSION_ACTIVE_O;
  endproperty
  a_keep: assert property (p_keep) else $error("active dropped early");
  property p_irq; RESULT_UPDATE_O && mask_on |=> IRQ_O; endproperty
  a_irq: assert property (p_irq) else $error("no interrupt after commit");
  property p_rd; READ_I && ADDR_I == 4'h5 |=> RDATA_O == 16'($past(RESULT_O)); endproperty
  a_rd: assert property (p_rd) else $error("result readback wrong");
  property p_abort; WRITE_I && ADDR_I < 4'h3 && !$past(SAMPLE_VALID_I) |=> !RESULT_UPDATE_O;
  endproperty
  a_abort: assert property (p_abort) else $error("commit after abort");
  c_commit: cover property (RESULT_UPDATE_O);
  c_avg_end: cover property ($fell(CONVERSION_ACTIVE_O));
  c_irq: cover property ($rose(IRQ_O));
endmodule
`default_nettype wire

// >>> test/adc_conv_engine.sv
// Behavioural conversion engine that hands finished results to the block.
`timescale 1ns/1ps
`default_nettype none
module adc_conv_engine (
  input  wire logic        clk_i,
  output var  logic [15:0] sample_o,
  output var  logic        valid_o
);
  initial begin
    sample_o = 16'h5a5a;
    valid_o = 1'b0;
  end
  // Between results the data lines toggle, so stale data is never mistaken for fresh.
  task automatic run(input logic [15:0] v0, input logic [15:0] step, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      sample_o <= v0 + step * 16'(i);
      valid_o <= 1'b1;
      repeat (gap) begin
        @(posedge clk_i);
        sample_o <= ~sample_o;
        valid_o <= 1'b0;
      end
    end
    @(posedge clk_i);
    sample_o <= ~sample_o;
    valid_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> test/adc_avg_cmp_tb_top.sv
// Self-checking testbench of the average and compare logic.
`timescale 1ns/1ps
`default_nettype none
module adc_avg_cmp_tb_top;
  logic clk, rst_n, wr_en, rd_en, lp, valid, upd, act, irq;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, sample, result, last;
  int err_count, checks_done, n;
  adc_avg_cmp #(.WIDTH(16)) u_adc_avg_cmp (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WRITE_I(wr_en), .READ_I(rd_en), .RDATA_O(rdata), .SAMPLE_I(sample),
    .SAMPLE_VALID_I(valid), .LOW_POWER_I(lp), .CONVERSION_ACTIVE_O(act),
    .RESULT_UPDATE_O(upd), .RESULT_O(result), .IRQ_O(irq));
  adc_conv_engine u_adc_conv_engine (.clk_i(clk), .sample_o(sample), .valid_o(valid));
  task chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look just after that edge.
  task rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // One single result against one compare setting; a false compare leaves the result and the interrupt alone.
  task cmp(input logic [15:0] m, input logic [15:0] c1, c2, v, input logic e);
    wr(4'h1, c1);
    wr(4'h2, c2);
    wr(4'h0, m);
    u_adc_conv_engine.run(v, 16'h0000, 1, 0);
    wt(2);
    chk(irq, e);
    if (e) last = v;
    chk(result, last);
    wr(4'h3, 16'h0001);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog: a hang counts as a mismatch and goes to the verdict.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run;
  end
  initial begin
    {rst_n, wr_en, rd_en, lp, addr, wdata, err_count, checks_done} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(4'h0, 16'h0000);
    chk(result, 16'h0000);
    wr(4'h4, 16'h0001);
    u_adc_conv_engine.run(16'h1234, 16'h0000, 1, 0);
    wt(2);
    chk(result, 16'h1234);
    chk(irq, 1'b1);
    rdc(4'h3, 16'h0001);
    rdc(4'hf, 16'h0000);
    wr(4'h3, 16'h0001);
    wt(1);
    chk(irq, 1'b0);
    wr(4'h4, 16'h0000);
    u_adc_conv_engine.run(16'h4321, 16'h0000, 1, 0);
    wt(2);
    chk(irq, 1'b0);
    wr(4'h4, 16'h0001);
    wt(1);
    chk(irq, 1'b1);
    wr(4'h3, 16'h0001);
    $display("test single done");
    lp <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      n = 4 << s;
      wr(4'h0, 16'h0001 | 16'(s << 1));
      u_adc_conv_engine.run(16'h0100, 16'h0003, n - 1, s % 2);
      rdc(4'h3, 16'h0006);
      chk(act, 1'b1);
      u_adc_conv_engine.run(16'h0100 + 16'(3 * (n - 1)), 16'h0000, 1, 0);
      wt(2);
      chk(result, 16'((n * 256 + 3 * n * (n - 1) / 2) >> (s + 2)));
      chk(irq, 1'b1);
      wr(4'h3, 16'h0001);
    end
    $display("test average done");
    last = result;
    cmp(16'h0008, 16'h0064, 16'h00c8, 16'h0064, 1'b0);
    cmp(16'h0008, 16'h0064, 16'h00c8, 16'h0063, 1'b1);
    cmp(16'h0018, 16'h0064, 16'h00c8, 16'h0064, 1'b1);
    cmp(16'h0018, 16'h0064, 16'h00c8, 16'h0063, 1'b0);
    cmp(16'h0028, 16'h0064, 16'h00c8, 16'h00c8, 1'b0);
    cmp(16'h0028, 16'h0064, 16'h00c8, 16'h00c9, 1'b1);
    cmp(16'h0028, 16'h00c8, 16'h0064, 16'h0080, 1'b1);
    cmp(16'h0028, 16'h00c8, 16'h0064, 16'h0064, 1'b0);
    cmp(16'h0038, 16'h0064, 16'h00c8, 16'h00c8, 1'b1);
    cmp(16'h0038, 16'h0064, 16'h00c8, 16'h00c9, 1'b0);
    cmp(16'h0038, 16'h00c8, 16'h0064, 16'h0064, 1'b1);
    cmp(16'h0038, 16'h00c8, 16'h0064, 16'h0080, 1'b0);
    $display("test compare done");
    wr(4'h1, 16'h0011);
    wr(4'h0, 16'h0009);
    u_adc_conv_engine.run(16'h0010, 16'h0000, 3, 0);
    u_adc_conv_engine.run(16'h0013, 16'h0000, 1, 0);
    wt(2);
    chk(result, 16'h0010);
    wr(4'h3, 16'h0001);
    wr(4'h0, 16'h0001);
    u_adc_conv_engine.run(16'h0200, 16'h0000, 2, 0);
    wr(4'h0, 16'h0041);
    wt(1);
    chk(result, 16'h0010);
    u_adc_conv_engine.run(16'h0300, 16'h0004, 4, 0);
    wt(2);
    chk(result, 16'h0306);
    rdc(4'h5, 16'h0306);
    @(posedge clk);
    #1 chk(rdata, 16'h0000);
    rdc(4'h6, 16'h030c);
    $display("test abort done");
    complete_run;
  end
endmodule
bind adc_avg_cmp adc_avg_cmp_chk #(.WIDTH(WIDTH)) u_adc_avg_cmp_chk (.CLK_I(CLK_I),
  .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WRITE_I(WRITE_I),
  .READ_I(READ_I), .RDATA_O(RDATA_O), .SAMPLE_VALID_I(SAMPLE_VALID_I),
  .CONVERSION_ACTIVE_O(CONVERSION_ACTIVE_O), .RESULT_UPDATE_O(RESULT_UPDATE_O),
  .RESULT_O(RESULT_O), .IRQ_O(IRQ_O));
`default_nettype wire
